// ==== rtl/mode_loader_pkg.sv ====
package mode_loader_pkg;

	localparam logic [31:0] MODE_VECTOR_ADDR  = 32'h000FFFF8;
	localparam logic [31:0] RESET_VECTOR_ADDR = 32'h000FFFFC;
	localparam int          MODE_BYTE_MSB     = 31;
	localparam int          MODE_BYTE_LSB     = 24;
	localparam logic [7:0]  MODE_BYTE_RESET   = 8'h00;
	localparam logic [7:0]  MODE_BYTE_EXPECT  = 8'h07;
	localparam logic [2:0]  STRAP_INT_ROM     = 3'h0;
	localparam int          STRAP_COUNT       = 4;
	localparam int          STRAP_AREA_MSB    = 2;
	localparam int          STRAP_FIXED_BIT   = 3;
	// Only strobe 3 set: a lone byte write on the mode byte lane
	localparam logic [3:0]  STRB_MODE_LANE    = 4'h8;

	// APB register offsets
	localparam logic [11:0] OFS_MODE   = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_RVEC   = 12'h008;

	// Status register field positions
	localparam int ST_DONE     = 0;
	localparam int ST_EXT_AREA = 1;
	localparam int ST_BAD_STRAP = 2;
	localparam int ST_BAD_MODE = 3;
	localparam int ST_STRAP_LSB = 4;

	// Transfer sizes on the emulator write path
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_MREQ   = 2'b01,
		ST_RREQ   = 2'b11,
		ST_RUN    = 2'b10
	} boot_state_e;

	typedef struct packed {
		logic        req;
		logic        ext_area;
		logic [31:0] addr;
	} fetch_req_s;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} fetch_rsp_s;

endpackage : mode_loader_pkg

// ==== rtl/strap_capture.sv ====
`timescale 1ns/100ps
module strap_capture #(
	parameter int WIDTH = 4
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             hold,
	input  wire logic [WIDTH-1:0] pins,
	output logic      [WIDTH-1:0] value
);
	if (WIDTH < 1) begin : g_bad_width
		$error("strap_capture: WIDTH must be positive");
	end

	// Follows the pins until hold rises; constant under async reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			value <= '0;
		else if (!hold)
			value <= pins;
	end

endmodule : strap_capture

// ==== rtl/reset_mode_vector_loader.sv ====
`timescale 1ns/100ps
module reset_mode_vector_loader (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        boot_strap_bit0,
	input  wire logic                        boot_strap_bit1,
	input  wire logic                        boot_strap_bit2,
	input  wire logic                        boot_strap_bit3,
	input  wire logic                        emulator_mode,
	output mode_loader_pkg::fetch_req_s      fetch_req,
	input  wire mode_loader_pkg::fetch_rsp_s fetch_rsp,
	output logic [7:0]                       operating_mode,
	output logic                             cpu_start,
	output logic [31:0]                      reset_vector,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [11:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	input  wire logic [3:0]                  pstrb,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr
);
	mode_loader_pkg::boot_state_e state_reg, state_next;
	mode_loader_pkg::fetch_req_s  req_reg, req_next;
	logic [7:0]  mode_reg, mode_next;
	logic [31:0] rvec_reg, rvec_next;
	logic        start_reg, start_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        pready_reg, pready_next;
	logic        pslverr_reg, pslverr_next;
	logic [31:0] status_word;
	logic [mode_loader_pkg::STRAP_COUNT-1:0] straps;

	// The mode byte must be one byte and sit at the top of the bus word
	if ((mode_loader_pkg::MODE_BYTE_MSB - mode_loader_pkg::MODE_BYTE_LSB + 1
	     != $bits(mode_reg))
	    || (mode_loader_pkg::MODE_BYTE_MSB != $bits(prdata) - 1))
	begin : g_bad_lane
		$error("mode byte slice does not match the register");
	end
	if (mode_loader_pkg::ST_STRAP_LSB + mode_loader_pkg::STRAP_COUNT
	    > $bits(status_word)) begin : g_bad_status
		$error("strap field does not fit the status word");
	end

	// Pin order follows the strap numbering, bit 0 lowest
	wire logic [mode_loader_pkg::STRAP_COUNT-1:0] strap_pins = {
		boot_strap_bit3, boot_strap_bit2, boot_strap_bit1, boot_strap_bit0};

	// Straps track the pins while idle, frozen once the fetch begins
	strap_capture #(
		.WIDTH (mode_loader_pkg::STRAP_COUNT)
	) u_strap (
		.pclk    (pclk),
		.presetn (presetn),
		.hold    (state_reg != mode_loader_pkg::ST_IDLE),
		.pins    (strap_pins),
		.value   (straps)
	);

	// The first request is built from the live pins: the captured copy
	// is only loaded on that same edge and would still hold its reset value
	wire logic pin_ext_area =
		strap_pins[mode_loader_pkg::STRAP_AREA_MSB:0]
		!= mode_loader_pkg::STRAP_INT_ROM;
	wire logic ext_area =
		straps[mode_loader_pkg::STRAP_AREA_MSB:0]
		!= mode_loader_pkg::STRAP_INT_ROM;
	// Forbidden straps are only flagged; the fetch still goes ahead
	wire logic bad_strap =
		ext_area | straps[mode_loader_pkg::STRAP_FIXED_BIT];
	wire logic bad_mode  = mode_reg != mode_loader_pkg::MODE_BYTE_EXPECT;
	wire logic [7:0] fetched_byte =
		fetch_rsp.data[mode_loader_pkg::MODE_BYTE_MSB:
		               mode_loader_pkg::MODE_BYTE_LSB];

	// APB decode
	wire logic access   = psel & penable & pready_reg;
	wire logic setup    = psel & !penable;
	wire logic hit_mode = paddr == mode_loader_pkg::OFS_MODE;
	wire logic hit_stat = paddr == mode_loader_pkg::OFS_STATUS;
	wire logic hit_rvec = paddr == mode_loader_pkg::OFS_RVEC;
	wire logic hit_any  = hit_mode | hit_stat | hit_rvec;
	// Byte lane of the mode byte in big-endian order is strobe 3
	wire logic byte_xfer = pstrb == mode_loader_pkg::STRB_MODE_LANE;
	// Wider writes are dropped silently, with no error response
	wire logic mode_wr = access & pwrite & hit_mode & emulator_mode
	                     & byte_xfer;

	// Read data is chosen in the setup cycle so it stands registered
	// in the access cycle
	wire logic [31:0] mode_word =
		{mode_reg, {mode_loader_pkg::MODE_BYTE_LSB{1'b0}}};
	wire logic [31:0] read_word =
		hit_mode ? mode_word :
		hit_stat ? status_word :
		hit_rvec ? rvec_reg : '0;

	// Status fields sit at fixed positions, the rest reads as zero
	always_comb begin
		status_word = '0;
		status_word[mode_loader_pkg::ST_DONE]      = start_reg;
		status_word[mode_loader_pkg::ST_EXT_AREA]  = ext_area;
		status_word[mode_loader_pkg::ST_BAD_STRAP] = bad_strap;
		status_word[mode_loader_pkg::ST_BAD_MODE]  = bad_mode;
		status_word[mode_loader_pkg::ST_STRAP_LSB +:
		            mode_loader_pkg::STRAP_COUNT] = straps;
	end

	always_comb begin
		state_next = state_reg;
		req_next   = req_reg;
		mode_next  = mode_reg;
		rvec_next  = rvec_reg;
		unique case (state_reg)
			mode_loader_pkg::ST_IDLE: begin
				req_next.req      = 1'b1;
				req_next.ext_area = pin_ext_area;
				req_next.addr     = mode_loader_pkg::MODE_VECTOR_ADDR;
				state_next        = mode_loader_pkg::ST_MREQ;
			end
			mode_loader_pkg::ST_MREQ: begin
				if (fetch_rsp.valid) begin
					mode_next     = fetched_byte;
					req_next.addr = mode_loader_pkg::RESET_VECTOR_ADDR;
					state_next    = mode_loader_pkg::ST_RREQ;
				end
			end
			mode_loader_pkg::ST_RREQ: begin
				if (fetch_rsp.valid) begin
					rvec_next    = fetch_rsp.data;
					req_next.req = 1'b0;
					state_next   = mode_loader_pkg::ST_RUN;
				end
			end
			mode_loader_pkg::ST_RUN: begin
				if (mode_wr)
					mode_next = pwdata[mode_loader_pkg::MODE_BYTE_MSB:
					                   mode_loader_pkg::MODE_BYTE_LSB];
			end
		endcase
	end

	// Execution may start only once both vectors are in
	assign start_next = state_next == mode_loader_pkg::ST_RUN;

	// Zero-wait slave: pready rises in the first access cycle
	always_comb begin
		prdata_next  = prdata_reg;
		pslverr_next = 1'b0;
		pready_next  = setup;
		if (setup) begin
			prdata_next  = pwrite ? '0 : read_word;
			pslverr_next = !hit_any;
		end
	end

	// Every reset source funnels into presetn, so each one restarts the fetch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= mode_loader_pkg::ST_IDLE;
			req_reg   <= '0;
		end else begin
			state_reg <= state_next;
			req_reg   <= req_next;
		end
	end

	// Holds 00h until the fetch lands, never a stale mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode_reg <= mode_loader_pkg::MODE_BYTE_RESET;
		else
			mode_reg <= mode_next;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rvec_reg <= '0;
		else
			rvec_reg <= rvec_next;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			start_reg <= 1'b0;
		else
			start_reg <= start_next;
	end

	// Registered bus outputs cost the one access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg  <= '0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign fetch_req      = req_reg;
	assign operating_mode = mode_reg;
	assign cpu_start      = start_reg;
	assign reset_vector   = rvec_reg;
	assign prdata         = prdata_reg;
	assign pready         = pready_reg;
	assign pslverr        = pslverr_reg;

endmodule : reset_mode_vector_loader

// ==== bench/boot_memory_model.sv ====
`timescale 1ns/100ps
module boot_memory_model #(
	parameter logic [31:0] RVEC = 32'h00004000
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic [3:0]                  lag,
	input  wire mode_loader_pkg::fetch_req_s fetch_req,
	output mode_loader_pkg::fetch_rsp_s      fetch_rsp
);
	logic [3:0] cnt_reg;
	wire        due = fetch_req.req && !fetch_rsp.valid && cnt_reg == lag;
	wire        hit = fetch_req.addr == mode_loader_pkg::MODE_VECTOR_ADDR;
	wire [31:0] word = hit ? {8'h07, 24'hC35A96} : RVEC;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 4'h0;
			fetch_rsp <= '0;
		end else begin
			cnt_reg <= (fetch_req.req && !due && !fetch_rsp.valid) ?
				cnt_reg + 4'h1 : 4'h0;
			fetch_rsp.valid <= due;
			// Idle bus toggles so stale data never passes for an answer
			fetch_rsp.data <= due ? word : ~fetch_rsp.data;
		end
	end
endmodule : boot_memory_model

// ==== bench/mode_loader_checker.sv ====
`timescale 1ns/100ps
module mode_loader_checker (
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic [2:0]                  straps,
	input wire logic                        emulator_mode,
	input wire mode_loader_pkg::fetch_req_s fetch_req,
	input wire mode_loader_pkg::fetch_rsp_s fetch_rsp,
	input wire logic [7:0]                  operating_mode,
	input wire logic                        cpu_start,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [11:0]                 paddr,
	input wire logic [31:0]                 pwdata,
	input wire logic [3:0]                  pstrb,
	input wire logic                        pready
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire take = fetch_req.req && fetch_rsp.valid;
	wire mv = fetch_req.addr == mode_loader_pkg::MODE_VECTOR_ADDR;
	wire wr = psel && penable && pready && pwrite && cpu_start &&
		paddr == mode_loader_pkg::OFS_MODE;
	wire lane = pstrb == mode_loader_pkg::STRB_MODE_LANE;
	property p_area; fetch_req.req |-> fetch_req.ext_area == |straps; endproperty
	a_area: assert property (p_area) else $error("area");
	property p_load; take && mv |=> operating_mode ==
		$past(fetch_rsp.data[31:24]) && fetch_req.req && !mv; endproperty
	a_load: assert property (p_load) else $error("load");
	property p_start; take && !mv |=> !fetch_req.req && cpu_start; endproperty
	a_start: assert property (p_start) else $error("start");
	property p_wait; fetch_req.req && !fetch_rsp.valid |=>
		fetch_req.req && $stable(fetch_req.addr); endproperty
	a_wait: assert property (p_wait) else $error("wait");
	property p_user; wr && !emulator_mode |=> $stable(operating_mode); endproperty
	a_user: assert property (p_user) else $error("user");
	property p_wide; wr && !lane |=> $stable(operating_mode); endproperty
	a_wide: assert property (p_wide) else $error("wide");
	property p_emu; wr && emulator_mode && lane |=>
		operating_mode == $past(pwdata[31:24]); endproperty
	a_emu: assert property (p_emu) else $error("emu");
	property p_hold; cpu_start && !wr |=> $stable(operating_mode); endproperty
	a_hold: assert property (p_hold) else $error("hold");
endmodule : mode_loader_checker
bind reset_mode_vector_loader mode_loader_checker i_mode_loader_checker (
	.pclk(pclk), .presetn(presetn), .emulator_mode(emulator_mode),
	.straps({boot_strap_bit2, boot_strap_bit1, boot_strap_bit0}),
	.fetch_req(fetch_req), .fetch_rsp(fetch_rsp), .cpu_start(cpu_start),
	.operating_mode(operating_mode), .psel(psel), .penable(penable),
	.pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready));

// ==== bench/tb_reset_mode_vector_loader.sv ====
`timescale 1ns/100ps
module tb_reset_mode_vector_loader;
	localparam logic [31:0] RVEC = 32'h00004000;
	logic pclk = 0, presetn = 0, emulator_mode = 0;
	logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, cpu_start, er;
	logic [3:0] lag = 4'h0, pstrb = 4'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rv, rd;
	logic [7:0] operating_mode;
	mode_loader_pkg::fetch_req_s fetch_req;
	mode_loader_pkg::fetch_rsp_s fetch_rsp;
	int num_errors = 0, check_count = 0;
	always #25 pclk = ~pclk;
	// Board straps all low: internal boot area, fourth pin grounded
	reset_mode_vector_loader i_reset_mode_vector_loader (.pclk(pclk),
		.presetn(presetn), .boot_strap_bit0(1'b0), .boot_strap_bit1(1'b0),
		.boot_strap_bit2(1'b0), .boot_strap_bit3(1'b0), .psel(psel),
		.emulator_mode(emulator_mode), .fetch_req(fetch_req), .pstrb(pstrb),
		.fetch_rsp(fetch_rsp), .operating_mode(operating_mode), .paddr(paddr),
		.cpu_start(cpu_start), .reset_vector(rv), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	boot_memory_model #(.RVEC(RVEC)) i_boot_memory_model (.pclk(pclk),
		.presetn(presetn), .lag(lag), .fetch_req(fetch_req),
		.fetch_rsp(fetch_rsp));
	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input string n, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'h2, w, a, d, s};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 9);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
		if (pready !== 1'b1) begin
			num_errors++;
			complete_run();
		end
	endtask : apb
	task automatic boot(input logic [3:0] l);
		int n;
		n = 0;
		lag <= l;
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (cpu_start !== 1'b1 && n < 60);
		chk("start", {31'h0, cpu_start}, 32'h1);
		if (cpu_start !== 1'b1) complete_run();
		@(negedge pclk);
		chk("mode", {24'h0, operating_mode}, 32'h07);
		chk("vector", rv, RVEC);
		apb(1'b0, mode_loader_pkg::OFS_MODE, 32'h0, 4'h0);
		chk("read", {24'h0, rd[31:24]}, 32'h07);
		apb(1'b0, mode_loader_pkg::OFS_STATUS, 32'h0, 4'h0);
		chk("status", rd, 32'h00000001);
		$display("boot test end");
	endtask : boot
	task automatic wr(input logic em, input logic [3:0] s, input logic [7:0] x);
		emulator_mode <= em;
		apb(1'b1, mode_loader_pkg::OFS_MODE, 32'h5A000000, s);
		@(negedge pclk);
		chk("mode write", {24'h0, operating_mode}, {24'h0, x});
		$display("write test end");
	endtask : wr
	initial begin
		boot(4'h0);
		wr(1'b0, 4'h8, 8'h07);
		wr(1'b1, 4'hF, 8'h07);
		wr(1'b1, 4'hC, 8'h07);
		wr(1'b1, 4'h8, 8'h5A);
		apb(1'b0, mode_loader_pkg::OFS_STATUS, 32'h0, 4'h0);
		chk("bad mode", rd, 32'h00000009);
		apb(1'b0, 12'h0FC, 32'h0, 4'h0);
		chk("unmapped", {31'h0, er}, 32'h1);
		boot(4'h3);
		complete_run();
	end
endmodule : tb_reset_mode_vector_loader
